/* File: hw/gtm_map.svh */
// Register offsets, field positions, reset values and counts of the timer block
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

`define GTM_AW               8
`define GTM_DW               32

`define GTM_OFF_CFG          8'h00
`define GTM_OFF_MODE         8'h04
`define GTM_OFF_CTL          8'h0c
`define GTM_OFF_IMR          8'h18
`define GTM_OFF_RIS          8'h1c
`define GTM_OFF_MIS          8'h20
`define GTM_OFF_ICR          8'h24
`define GTM_OFF_ILR          8'h28
`define GTM_OFF_MATCH        8'h30
`define GTM_OFF_PRE          8'h38
`define GTM_OFF_TVAL         8'h48

`define GTM_CFG_32           3'h0
`define GTM_CFG_RTC          3'h1
`define GTM_CFG_16           3'h4

`define GTM_TMR_ONESHOT      2'h1
`define GTM_TMR_PERIODIC     2'h2
`define GTM_TMR_CAPTURE      2'h3

`define GTM_CTL_EN           0
`define GTM_CTL_RTC_OVR      4
`define GTM_CTL_INV          6

`define GTM_EVT_RISE         2'h0
`define GTM_EVT_FALL         2'h1
`define GTM_EVT_BOTH         2'h3

`define GTM_FLG_TIMEOUT      0
`define GTM_FLG_MATCH        1
`define GTM_FLG_CAPTURE      2
`define GTM_FLG_RTC          3

`define GTM_ILR_RST          32'hffffffff
`define GTM_MATCH_RST        32'hffffffff
`define GTM_RTC_FIRST        32'h00000001
`define GTM_RTC_DIV          16'hffff

`endif

/* File: hw/gtm_pkg.sv */
// Types shared by the timer block
package gtm_pkg;

  typedef enum logic [2:0] {
    GTM_OP_NONE,
    GTM_OP_T32,
    GTM_OP_RTC,
    GTM_OP_T16,
    GTM_OP_ECOUNT,
    GTM_OP_ETIME,
    GTM_OP_PWM
  } gtm_op_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gtm_bus_req_t;

  typedef struct packed {
    logic ccp_out;
    logic ccp_oe;
  } gtm_pin_out_t;

endpackage

/* File: hw/gtm_timer.sv */
// General purpose timer: one-shot, periodic, RTC, edge count, edge time and PWM
`include "gtm_map.svh"

// Function
// - No prescaler in 16-bit edge time mode; count every clock.
// - Edge time: free-running down-counter from load value, reset 0xFFFF.
// - Capture rising, falling or both edges per event field; capture bit picks time.
// - Selected edge copies count to value register and sets capture flags.
// - Edge time keeps counting after capture, reloads at zero.
// - Captured count held until next selected edge.
// - PWM counts down without prescaler from load value, setting period.
// - PWM counter reloads after zero and repeats until disabled.
// - PWM mode sets no interrupt or status flags.
// - PWM output asserts at load value, deasserts at match value.
// - Invert bit flips PWM output polarity.
// - PWM load write changes period next cycle without disabling.
// - Edge time load write takes effect next cycle while running.
// - Config 0 = 32-bit timer, 1 = RTC, 4 = 16-bit; mode 1 one-shot, 2 periodic.
// - One-shot stops after time-out; periodic keeps counting.
// - Capture bit 0 with mode 3 edge count; bit 1 with mode 3 edge time.
// - Edge count stops after programmed edges until re-enabled.
// - RTC sets flag on match, keeps counting, flag cleared by clear bit.
// - Status flags cleared only by writing one to clear register.
// - Timer reaching zero sets time-out flag, masked flag when unmasked.
// - Edge count decrements per edge to match, then flag, reload, disable.
module gtm_timer
  import gtm_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_sys_rst,
  input  wire gtm_bus_req_t i_bus,
  output logic [31:0]       o_rdata,
  input  wire logic         i_ccp,
  output gtm_pin_out_t      o_ccp,
  output logic              o_irq_any
);

  logic [2:0]  global_config_reg;
  logic [3:0]  half_mode_reg;
  logic [6:0]  control_reg;
  logic [3:0]  irq_mask_reg;
  logic [3:0]  raw_irq_status_reg;
  logic [31:0] interval_load_reg;
  logic [31:0] match_value_reg;
  logic [7:0]  prescale_reg;
  logic [31:0] timer_value_reg;
  logic [31:0] cnt_reg;
  logic [7:0]  pre_cnt_reg;
  logic [15:0] rtc_div_reg;
  logic        en_d_reg;
  logic        sync1_reg;
  logic        sync2_reg;
  logic        sync3_reg;
  logic        pwm_lvl_reg;
  logic        pwm_out_reg;
  logic        pwm_oe_reg;
  logic [31:0] rdata_reg;

  gtm_op_t     op;
  logic        en;
  logic        start;
  logic        tick;
  logic        edge_sel;
  logic        rise;
  logic        fall;
  logic        ilr_wr;
  logic        icr_wr;
  logic [31:0] ilr_m;
  logic [31:0] match_m;
  logic [31:0] cnt_dec;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic [3:0]  masked;

  // Cut to 16 bits when the halves run separately
  function automatic logic [31:0] f_fit(input logic [2:0] cfg, input logic [31:0] v);
    f_fit = (cfg[2]) ? {16'h0000, v[15:0]} : v;
  endfunction

  function automatic logic f_hit(input logic [31:0] a, input logic [31:0] b,
                                 input logic [2:0] cfg);
    f_hit = (f_fit(cfg, a) == f_fit(cfg, b));
  endfunction

  // Operating mode decode
  always_comb begin
    op = GTM_OP_NONE;
    if (global_config_reg == `GTM_CFG_32) begin
      if (half_mode_reg[1:0] == `GTM_TMR_ONESHOT || half_mode_reg[1:0] == `GTM_TMR_PERIODIC)
        op = GTM_OP_T32;
    end else if (global_config_reg == `GTM_CFG_RTC) begin
      op = GTM_OP_RTC;
    end else if (global_config_reg[2]) begin
      if (half_mode_reg[3] && !half_mode_reg[2] &&
          half_mode_reg[1:0] == `GTM_TMR_PERIODIC) begin
        op = GTM_OP_PWM;
      end else if (half_mode_reg[1:0] == `GTM_TMR_CAPTURE) begin
        op = half_mode_reg[2] ? GTM_OP_ETIME : GTM_OP_ECOUNT;
      end else if (half_mode_reg[1:0] != 2'h0) begin
        op = GTM_OP_T16;
      end
    end
  end

  assign en      = control_reg[`GTM_CTL_EN];
  assign start   = en && !en_d_reg;
  assign ilr_m   = f_fit(global_config_reg, interval_load_reg);
  assign match_m = f_fit(global_config_reg, match_value_reg);
  assign cnt_dec = f_fit(global_config_reg, cnt_reg - 32'h00000001);
  assign ilr_wr  = i_bus.wr && (i_bus.addr == `GTM_OFF_ILR);
  assign icr_wr  = i_bus.wr && (i_bus.addr == `GTM_OFF_ICR);

  // Two-stage synchroniser, edge detect only after it
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= i_ccp;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg && !sync3_reg;
  assign fall = !sync2_reg && sync3_reg;

  always_comb begin
    case (control_reg[3:2])
      `GTM_EVT_RISE: edge_sel = rise;
      `GTM_EVT_FALL: edge_sel = fall;
      `GTM_EVT_BOTH: edge_sel = rise || fall;
      default:       edge_sel = 1'b0;
    endcase
  end

  // Prescaler only serves the 16-bit one-shot/periodic timer
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pre_cnt_reg <= 8'h00;
    end else if (start || op != GTM_OP_T16 || pre_cnt_reg == 8'h00) begin
      pre_cnt_reg <= prescale_reg;
    end else begin
      pre_cnt_reg <= pre_cnt_reg - 8'h01;
    end
  end

  // RTC pin clock divided to one tick per second
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || start || op != GTM_OP_RTC) begin
      rtc_div_reg <= 16'h0000;
    end else if (rise) begin
      rtc_div_reg <= rtc_div_reg + 16'h0001;
    end
  end

  always_comb begin
    case (op)
      GTM_OP_T16: tick = (pre_cnt_reg == 8'h00);
      GTM_OP_RTC: tick = rise && (rtc_div_reg == `GTM_RTC_DIV);
      default:    tick = 1'b1;
    endcase
  end

  // Main counter
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_reg <= `GTM_ILR_RST;
    end else if (start) begin
      cnt_reg <= (op == GTM_OP_RTC) ? `GTM_RTC_FIRST : ilr_m;
    end else if (en && ilr_wr && (op == GTM_OP_PWM || op == GTM_OP_ETIME ||
                                  op == GTM_OP_T16 || op == GTM_OP_T32)) begin
      cnt_reg <= f_fit(global_config_reg, i_bus.wdata);
    end else if (en) begin
      case (op)
        GTM_OP_T32, GTM_OP_T16, GTM_OP_ETIME, GTM_OP_PWM: begin
          if (tick) begin
            if (f_fit(global_config_reg, cnt_reg) == 32'h00000000)
              cnt_reg <= ilr_m;
            else
              cnt_reg <= cnt_dec;
          end
        end
        GTM_OP_ECOUNT: begin
          if (edge_sel) begin
            if (cnt_dec == match_m)
              cnt_reg <= ilr_m;
            else
              cnt_reg <= cnt_dec;
          end
        end
        GTM_OP_RTC: begin
          if (tick) begin
            if (cnt_reg == match_value_reg)
              cnt_reg <= 32'h00000000;
            else
              cnt_reg <= cnt_reg + 32'h00000001;
          end
        end
        default: cnt_reg <= cnt_reg;
      endcase
    end
  end

  // Event flags raised this cycle
  always_comb begin
    flag_set = 4'h0;
    if (en) begin
      case (op)
        GTM_OP_T32, GTM_OP_T16:
          flag_set[`GTM_FLG_TIMEOUT] = tick &&
            (f_fit(global_config_reg, cnt_reg) == 32'h00000000);
        GTM_OP_ECOUNT:
          flag_set[`GTM_FLG_MATCH] = edge_sel && (cnt_dec == match_m);
        GTM_OP_ETIME:
          flag_set[`GTM_FLG_CAPTURE] = edge_sel;
        GTM_OP_RTC:
          flag_set[`GTM_FLG_RTC] = tick && (cnt_reg == match_value_reg);
        default:
          flag_set = 4'h0;
      endcase
    end
  end

  assign flag_clr = icr_wr ? i_bus.wdata[3:0] : 4'h0;
  assign masked   = raw_irq_status_reg & irq_mask_reg;

  // A new event beats a clear in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst)
      raw_irq_status_reg <= 4'h0;
    else
      raw_irq_status_reg <= (raw_irq_status_reg & ~flag_clr) | flag_set;
  end

  // Captured count held between selected edges
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst)
      timer_value_reg <= `GTM_ILR_RST;
    else if (op == GTM_OP_ETIME && en && edge_sel)
      timer_value_reg <= f_fit(global_config_reg, cnt_reg);
  end

  // Control register, hardware clears enable on one-shot and edge count end
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      control_reg <= 7'h00;
    end else if (i_bus.wr && i_bus.addr == `GTM_OFF_CTL) begin
      control_reg <= i_bus.wdata[6:0];
    end else if (flag_set[`GTM_FLG_TIMEOUT] && half_mode_reg[1:0] == `GTM_TMR_ONESHOT) begin
      control_reg[`GTM_CTL_EN] <= 1'b0;
    end else if (flag_set[`GTM_FLG_MATCH]) begin
      control_reg[`GTM_CTL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst)
      en_d_reg <= 1'b0;
    else
      en_d_reg <= en;
  end

  // Configuration registers; settings assumed stable while enabled
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      global_config_reg <= 3'h0;
      half_mode_reg     <= 4'h0;
      irq_mask_reg      <= 4'h0;
      interval_load_reg <= `GTM_ILR_RST;
      match_value_reg   <= `GTM_MATCH_RST;
      prescale_reg      <= 8'h00;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `GTM_OFF_CFG)
        global_config_reg <= i_bus.wdata[2:0];
      else if (i_bus.addr == `GTM_OFF_MODE)
        half_mode_reg <= i_bus.wdata[3:0];
      else if (i_bus.addr == `GTM_OFF_IMR)
        irq_mask_reg <= i_bus.wdata[3:0];
      else if (i_bus.addr == `GTM_OFF_ILR)
        interval_load_reg <= i_bus.wdata;
      else if (i_bus.addr == `GTM_OFF_MATCH)
        match_value_reg <= i_bus.wdata;
      else if (i_bus.addr == `GTM_OFF_PRE)
        prescale_reg <= i_bus.wdata[7:0];
    end
  end

  // PWM level follows counter, registered so the pin never glitches
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pwm_lvl_reg <= 1'b0;
    end else if (op != GTM_OP_PWM || !en) begin
      pwm_lvl_reg <= 1'b0;
    end else if (f_hit(cnt_reg, interval_load_reg, global_config_reg)) begin
      pwm_lvl_reg <= 1'b1;
    end else if (f_hit(cnt_reg, match_value_reg, global_config_reg)) begin
      pwm_lvl_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pwm_out_reg <= 1'b0;
      pwm_oe_reg  <= 1'b0;
    end else begin
      pwm_out_reg <= pwm_lvl_reg ^ control_reg[`GTM_CTL_INV];
      pwm_oe_reg  <= (op == GTM_OP_PWM);
    end
  end

  assign o_ccp.ccp_out = pwm_out_reg;
  assign o_ccp.ccp_oe  = pwm_oe_reg;
  assign o_irq_any     = |masked;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_bus.rd)
      rdata_reg <= 32'h00000000;
    else if (i_bus.addr == `GTM_OFF_CFG)
      rdata_reg <= {29'h0, global_config_reg};
    else if (i_bus.addr == `GTM_OFF_MODE)
      rdata_reg <= {28'h0, half_mode_reg};
    else if (i_bus.addr == `GTM_OFF_CTL)
      rdata_reg <= {25'h0, control_reg};
    else if (i_bus.addr == `GTM_OFF_IMR)
      rdata_reg <= {28'h0, irq_mask_reg};
    else if (i_bus.addr == `GTM_OFF_RIS)
      rdata_reg <= {28'h0, raw_irq_status_reg};
    else if (i_bus.addr == `GTM_OFF_MIS)
      rdata_reg <= {28'h0, masked};
    else if (i_bus.addr == `GTM_OFF_ILR)
      rdata_reg <= interval_load_reg;
    else if (i_bus.addr == `GTM_OFF_MATCH)
      rdata_reg <= match_value_reg;
    else if (i_bus.addr == `GTM_OFF_PRE)
      rdata_reg <= {24'h0, prescale_reg};
    else if (i_bus.addr == `GTM_OFF_TVAL)
      rdata_reg <= (op == GTM_OP_ETIME) ? timer_value_reg : cnt_reg;
    else
      rdata_reg <= 32'h00000000;
  end

  assign o_rdata = rdata_reg;

  property p_pwm_no_flags;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_PWM) |=> ((raw_irq_status_reg & ~$past(raw_irq_status_reg)) == 4'h0);
  endproperty
  a_pwm_no_flags: assert property (p_pwm_no_flags) else $error("flag set in pwm mode");

  property p_capture_copy;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_ETIME && en && edge_sel) |=>
        (timer_value_reg == f_fit(global_config_reg, $past(cnt_reg)))
        && raw_irq_status_reg[`GTM_FLG_CAPTURE];
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture not taken");

  property p_capture_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_ETIME && !edge_sel) ##1 (op == GTM_OP_ETIME && !edge_sel)
        |=> $stable(timer_value_reg);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("capture changed");

  property p_ecount_stop;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_ECOUNT && en && edge_sel && cnt_dec == match_m && !i_bus.wr) |=>
        !en && (cnt_reg == ilr_m) && raw_irq_status_reg[`GTM_FLG_MATCH];
  endproperty
  a_ecount_stop: assert property (p_ecount_stop) else $error("edge count did not stop");

  property p_etime_reload;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_ETIME && en && !start && !ilr_wr && cnt_reg[15:0] == 16'h0000)
        |=> (cnt_reg == ilr_m);
  endproperty
  a_etime_reload: assert property (p_etime_reload) else $error("no reload at zero");

  property p_oneshot_stop;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_T32 && en && !start && !i_bus.wr && cnt_reg == 32'h00000000 &&
       half_mode_reg[1:0] == `GTM_TMR_ONESHOT) |=> !en ##1 $stable(cnt_reg);
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

  property p_pwm_idle;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (op == GTM_OP_PWM && !en) [*2] |=> (pwm_out_reg == $past(control_reg[`GTM_CTL_INV]));
  endproperty
  a_pwm_idle: assert property (p_pwm_idle) else $error("idle pwm level wrong");

  property p_clear;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (icr_wr && i_bus.wdata[0] && !flag_set[0]) |=> !raw_irq_status_reg[0];
  endproperty
  a_clear: assert property (p_clear) else $error("time-out flag not cleared");

endmodule // gtm_timer

/* File: testbench/tcpm_edge_source.sv */
// Edge source standing on the capture pin, toggling it on request
module tcpm_edge_source (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_go,
  input  wire logic [7:0] i_toggles,
  input  wire logic [7:0] i_hold,
  output logic            o_level,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] left_reg;
  logic [7:0] wait_reg;
  logic [7:0] hold_w;

  // Never shorter than two clocks, or the device may miss an edge
  assign hold_w = (i_hold < 8'h02) ? 8'h02 : i_hold;
  assign o_busy = (left_reg != 8'h00);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      left_reg <= 8'h00;
      wait_reg <= 8'h00;
      o_level  <= 1'b0;
    end else if (i_go && left_reg == 8'h00) begin
      left_reg <= i_toggles;
      wait_reg <= hold_w;
    end else if (left_reg != 8'h00) begin
      if (wait_reg > 8'h01) begin
        wait_reg <= wait_reg - 8'h01;
      end else begin
        o_level  <= ~o_level;
        left_reg <= left_reg - 8'h01;
        wait_reg <= hold_w;
      end
    end
  end
endmodule // tcpm_edge_source

/* File: testbench/test_timer_capture_pwm_modes.sv */
// Self-checking bench for the timer block: capture, edge count, timers, PWM
`include "gtm_map.svh"

module test_timer_capture_pwm_modes
  import gtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         i_clk_sys;
  logic         i_sys_rst;
  gtm_bus_req_t bus;
  logic [31:0]  rdata;
  gtm_pin_out_t pin_out;
  logic         irq_any;
  logic         src_go;
  logic [7:0]   src_toggles;
  logic         src_level;
  logic         pin_line;
  int           bad_count;
  int           check_count;
  int           cycle_count;

  assign pin_line = pin_out.ccp_oe ? pin_out.ccp_out : src_level;

  gtm_timer dut (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_bus     (bus),
    .o_rdata   (rdata),
    .i_ccp     (pin_line),
    .o_ccp     (pin_out),
    .o_irq_any (irq_any)
  );

  tcpm_edge_source src (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_go      (src_go),
    .i_toggles (src_toggles),
    .i_hold    (8'h03),
    .o_level   (src_level),
    .o_busy    ()
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Scenarios need about 800 cycles; ceiling leaves ample margin
  always @(posedge i_clk_sys) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_pin(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check_reg(nm, exp, v);
  endtask

  // Fixed length, so capture spacing in clocks is known exactly
  task automatic toggle(input logic [7:0] n);
    @(posedge i_clk_sys);
    src_toggles <= n;
    src_go      <= 1'b1;
    @(posedge i_clk_sys);
    src_go <= 1'b0;
    repeat (4 * n + 6) @(posedge i_clk_sys);
  endtask

  task automatic count_high(input int settle, input int n, output int h);
    repeat (settle) @(posedge i_clk_sys);
    h = 0;
    repeat (n) begin
      @(negedge i_clk_sys);
      h += pin_out.ccp_out;
    end
  endtask

  task automatic test_reset();
    logic [7:0]  adr [12] = '{`GTM_OFF_CFG, `GTM_OFF_MODE, `GTM_OFF_CTL, `GTM_OFF_IMR,
                              `GTM_OFF_RIS, `GTM_OFF_MIS, `GTM_OFF_ICR, `GTM_OFF_ILR,
                              `GTM_OFF_MATCH, `GTM_OFF_PRE, `GTM_OFF_TVAL, 8'h08};
    logic [31:0] exv [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                              `GTM_ILR_RST, `GTM_MATCH_RST, 32'h0, 32'hffffffff, 32'h0};
    for (int i = 0; i < 12; i++) begin
      chk_rd("reset value", adr[i], exv[i]);
    end
    check_pin("pin drive", 1'b0, pin_out.ccp_out);
    check_pin("pin enable", 1'b0, pin_out.ccp_oe);
    check_pin("irq", 1'b0, irq_any);
    wr(`GTM_OFF_RIS, 32'hf);
    wr(8'h08, 32'h5a5a5a5a);
    chk_rd("read-only flags", `GTM_OFF_RIS, 32'h0);
    chk_rd("unmapped", 8'h08, 32'h0);
  endtask

  task automatic test_edge_time();
    logic [31:0] v1;
    logic [31:0] v2;
    wr(`GTM_OFF_CFG, 32'h4);
    wr(`GTM_OFF_MODE, 32'h7);
    wr(`GTM_OFF_PRE, 32'h5);
    wr(`GTM_OFF_ILR, 32'hffff);
    wr(`GTM_OFF_IMR, 32'h4);
    wr(`GTM_OFF_CTL, 32'h1);
    toggle(8'd1);
    rd(`GTM_OFF_TVAL, v1);
    toggle(8'd1);
    chk_rd("held capture", `GTM_OFF_TVAL, v1);
    toggle(8'd1);
    rd(`GTM_OFF_TVAL, v2);
    // Rises 28 clocks apart; a prescaled count would move far less
    check_reg("capture spacing", 32'd28, (v1 - v2) & 32'hffff);
    chk_rd("capture flag", `GTM_OFF_MIS, 32'h4);
    check_pin("irq", 1'b1, irq_any);
    // Short load while running: count hits zero and reloads before the next rise
    wr(`GTM_OFF_ILR, 32'h10);
    toggle(8'd1);
    toggle(8'd1);
    chk_rd("capture after reload", `GTM_OFF_TVAL, 32'he);
    wr(`GTM_OFF_CTL, 32'h0);
    wr(`GTM_OFF_ICR, 32'h4);
    chk_rd("capture flag cleared", `GTM_OFF_RIS, 32'h0);
  endtask

  task automatic test_edge_count();
    wr(`GTM_OFF_MODE, 32'h3);
    wr(`GTM_OFF_CTL, 32'hc);
    wr(`GTM_OFF_ILR, 32'ha);
    wr(`GTM_OFF_MATCH, 32'h6);
    wr(`GTM_OFF_IMR, 32'h2);
    wr(`GTM_OFF_CTL, 32'hd);
    toggle(8'd6);
    chk_rd("match flag", `GTM_OFF_RIS, 32'h2);
    chk_rd("enable after count", `GTM_OFF_CTL, 32'hc);
    chk_rd("counter reloaded", `GTM_OFF_TVAL, 32'ha);
    check_pin("irq", 1'b1, irq_any);
    wr(`GTM_OFF_ICR, 32'h2);
    chk_rd("match flag cleared", `GTM_OFF_RIS, 32'h0);
  endtask

  task automatic test_timers();
    logic [2:0] cfg;
    logic [1:0] md;
    wr(`GTM_OFF_PRE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cfg = (i < 2) ? `GTM_CFG_32 : `GTM_CFG_16;
      md  = i[0] ? `GTM_TMR_PERIODIC : `GTM_TMR_ONESHOT;
      wr(`GTM_OFF_CTL, 32'h0);
      // No flag left over from the previous pass
      wr(`GTM_OFF_ICR, 32'hf);
      wr(`GTM_OFF_CFG, {29'h0, cfg});
      wr(`GTM_OFF_MODE, {30'h0, md});
      wr(`GTM_OFF_ILR, 32'd20);
      wr(`GTM_OFF_IMR, 32'h1);
      wr(`GTM_OFF_CTL, 32'h1);
      repeat (40) @(posedge i_clk_sys);
      chk_rd("timeout flag", `GTM_OFF_RIS, 32'h1);
      check_pin("irq", 1'b1, irq_any);
      chk_rd("enable after timeout", `GTM_OFF_CTL, {31'h0, i[0]});
      wr(`GTM_OFF_ICR, 32'h1);
      repeat (40) @(posedge i_clk_sys);
      chk_rd("flag after clear", `GTM_OFF_RIS, {31'h0, i[0]});
    end
    wr(`GTM_OFF_CTL, 32'h0);
    wr(`GTM_OFF_ICR, 32'h1);
    wr(`GTM_OFF_CFG, {29'h0, `GTM_CFG_RTC});
    wr(`GTM_OFF_CTL, 32'h1);
    // Pin clock edges, far fewer than one divided tick
    toggle(8'd4);
    chk_rd("rtc start count", `GTM_OFF_TVAL, `GTM_RTC_FIRST);
    wr(`GTM_OFF_CTL, 32'h0);
  endtask

  task automatic test_pwm();
    int h;
    wr(`GTM_OFF_CFG, {29'h0, `GTM_CFG_16});
    wr(`GTM_OFF_MODE, 32'ha);
    wr(`GTM_OFF_ILR, 32'd9);
    wr(`GTM_OFF_MATCH, 32'd3);
    wr(`GTM_OFF_IMR, 32'hf);
    repeat (3) @(negedge i_clk_sys);
    check_pin("idle drive", 1'b0, pin_out.ccp_out);
    wr(`GTM_OFF_CTL, 32'h1);
    count_high(10, 20, h);
    check_reg("high cycles", 32'd12, h);
    check_pin("pin enable", 1'b1, pin_out.ccp_oe);
    chk_rd("pwm flags", `GTM_OFF_RIS, 32'h0);
    check_pin("irq", 1'b0, irq_any);
    wr(`GTM_OFF_ILR, 32'd19);
    count_high(25, 40, h);
    check_reg("high cycles new period", 32'd32, h);
    wr(`GTM_OFF_CTL, 32'h0);
    wr(`GTM_OFF_CTL, 32'h40);
    repeat (3) @(negedge i_clk_sys);
    check_pin("idle drive inverted", 1'b1, pin_out.ccp_out);
    wr(`GTM_OFF_CTL, 32'h41);
    count_high(25, 40, h);
    check_reg("high cycles inverted", 32'd8, h);
    wr(`GTM_OFF_CTL, 32'h0);
  endtask

  initial begin
    i_sys_rst   = 1'b1;
    bus         = '0;
    src_go      = 1'b0;
    src_toggles = 8'h0;
    repeat (4) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    test_reset();
    test_edge_time();
    test_edge_count();
    test_timers();
    test_pwm();
    print_verdict();
  end
endmodule // test_timer_capture_pwm_modes
